/* File: shared/log_write_pkg.sv */
package log_write_pkg;

	localparam logic [7:0] OPC_LOG_WRITE_PIO = 8'h3f;
	localparam logic [7:0] OPC_LOG_WRITE_DMA = 8'h57;

	localparam int SECTOR_BYTES     = 512;
	localparam int WORD_BYTES       = 4;
	localparam int WORDS_PER_SECTOR = SECTOR_BYTES / WORD_BYTES;
	localparam int WORD_IDX_W       = 7;
	localparam logic [WORD_IDX_W-1:0] LAST_WORD_IDX = 7'h7f;

	localparam int LOG_ENTRIES = 32;
	localparam int LOG_IDX_W   = 5;

	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] OFS_SECTOR_COUNT = 8'h00;
	localparam logic [7:0] OFS_LOG_ADDRESS  = 8'h04;
	localparam logic [7:0] OFS_START_SECTOR = 8'h08;
	localparam logic [7:0] OFS_COMMAND      = 8'h0c;
	localparam logic [7:0] OFS_STATUS       = 8'h10;
	localparam logic [7:0] OFS_ERROR        = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h1c;
	localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h20;
	localparam logic [7:0] OFS_DIR_SELECT   = 8'h24;
	localparam logic [7:0] OFS_DIR_ENTRY    = 8'h28;

	localparam int STS_BSY = 7;
	localparam int STS_RDY = 6;
	localparam int STS_DRQ = 3;
	localparam int STS_ERR = 0;
	localparam int ERR_ABT = 2;
	localparam logic [7:0] STATUS_RESET = 8'h40;
	localparam logic [7:0] ERROR_RESET  = 8'h00;

	localparam int IRQ_W     = 3;
	localparam int IRQ_BLOCK = 0;
	localparam int IRQ_DONE  = 1;
	localparam int IRQ_ABORT = 2;

	localparam int DIR_SIZE_W  = 16;
	localparam int DIR_RO_BIT  = 16;
	localparam int DIR_SUP_BIT = 17;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CHECK = 2'b01,
		ST_XFER  = 2'b10
	} cmd_state_e;

	typedef struct packed {
		logic        supported;
		logic        readOnly;
		logic [15:0] sectors;
	} dir_entry_s;

endpackage

/* File: shared/log_cmd_if.sv */
`timescale 1ns/1ps
interface log_cmd_if;
	logic [7:0]                opcode;
	logic [15:0]               count;
	logic [15:0]               startSector;
	logic [7:0]                logAddr;
	log_write_pkg::dir_entry_s entry;
	logic                      isLogWrite;
	logic                      isDma;
	logic                      abort;
	logic                      load;
	logic                      take;
	logic                      sectorDone;
	logic                      lastWord;
	logic [6:0]                wordIdx;
	logic [15:0]               sectorOff;

	modport check (input opcode, count, startSector, logAddr, entry, output isLogWrite, isDma, abort);
	modport counter (input count, load, take, output sectorDone, lastWord, wordIdx, sectorOff);
	modport owner (output opcode, count, startSector, logAddr, entry, load, take,
		input isLogWrite, isDma, abort, sectorDone, lastWord, wordIdx, sectorOff);
endinterface

/* File: design/log_param_check.sv */
`timescale 1ns/1ps
module log_param_check (
	log_cmd_if.check chk
);
	logic        inRange;
	logic [16:0] endSector;

	always_comb
	begin
		chk.isDma = (chk.opcode == log_write_pkg::OPC_LOG_WRITE_DMA);
		chk.isLogWrite = (chk.opcode == log_write_pkg::OPC_LOG_WRITE_PIO) || chk.isDma;
		inRange = (chk.logAddr < 8'(log_write_pkg::LOG_ENTRIES));
		endSector = {1'b0, chk.startSector} + {1'b0, chk.count};
		// Every test is evaluated for both opcodes, so the DMA form aborts on exactly the same cases.
		chk.abort = !chk.isLogWrite
			|| !inRange
			|| !chk.entry.supported
			|| chk.entry.readOnly
			|| (chk.count == 16'h0000)
			|| (chk.count > chk.entry.sectors)
			|| (chk.startSector >= chk.entry.sectors)
			|| (endSector > {1'b0, chk.entry.sectors});
	end
endmodule

/* File: design/log_sector_count.sv */
`timescale 1ns/1ps
module log_sector_count (
	input  wire logic    clk_sys,
	input  wire logic    arst_n,
	log_cmd_if.counter   cnt
);
	typedef struct packed {
		logic [6:0]  wordIdx;
		logic [15:0] sectorOff;
		logic [15:0] remaining;
	} cnt_s;

	cnt_s st_q;
	cnt_s st_d;

	always_comb
	begin
		st_d = st_q;
		cnt.wordIdx = st_q.wordIdx;
		cnt.sectorOff = st_q.sectorOff;
		cnt.sectorDone = cnt.take && (st_q.wordIdx == log_write_pkg::LAST_WORD_IDX);
		cnt.lastWord = cnt.sectorDone && (st_q.remaining == 16'h0001);
		if (cnt.load)
		begin
			st_d.wordIdx = 7'h00;
			st_d.sectorOff = 16'h0000;
			st_d.remaining = cnt.count;
		end
		else if (cnt.take)
		begin
			st_d.wordIdx = st_q.wordIdx + 7'h01;
			if (cnt.sectorDone)
			begin
				st_d.sectorOff = st_q.sectorOff + 16'h0001;
				st_d.remaining = st_q.remaining - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule

/* File: design/log_write_command.sv */
`timescale 1ns/1ps
module log_write_command (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [31:0] hostData,
	input  wire logic        hostDataValid,
	output logic             hostDataReady,
	output logic             xferDma,
	output logic             logWrValid,
	output logic [7:0]       logWrLog,
	output logic [15:0]      logWrSector,
	output logic [6:0]       logWrWordIdx,
	output logic [31:0]      logWrData,
	output logic             irq
);
	typedef struct packed {
		logic                                                       awPend;
		logic [7:0]                                                 awAddr;
		logic                                                       wPend;
		logic [31:0]                                                wData;
		logic [3:0]                                                 wStrb;
		logic                                                       bValid;
		logic [1:0]                                                 bResp;
		logic                                                       rValid;
		logic [31:0]                                                rData;
		logic [1:0]                                                 rResp;
		log_write_pkg::cmd_state_e                                  state;
		logic [7:0]                                                 opcode;
		logic [15:0]                                                count;
		logic [7:0]                                                 logAddr;
		logic [15:0]                                                startSector;
		logic                                                       isDma;
		logic [7:0]                                                 status;
		logic [7:0]                                                 error;
		logic [log_write_pkg::IRQ_W-1:0]                            irqSts;
		logic [log_write_pkg::IRQ_W-1:0]                            irqEn;
		logic [log_write_pkg::LOG_IDX_W-1:0]                        dirSel;
		log_write_pkg::dir_entry_s [log_write_pkg::LOG_ENTRIES-1:0] dir;
		logic                                                       wrValid;
		logic [7:0]                                                 wrLog;
		logic [15:0]                                                wrSector;
		logic [6:0]                                                 wrWordIdx;
		logic [31:0]                                                wrData;
	} top_s;

	top_s st_q;
	top_s st_d;

	log_cmd_if cmd ();

	log_param_check u_check (
		.chk (cmd.check)
	);

	log_sector_count u_count (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.cnt     (cmd.counter)
	);

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic [31:0] dirWord(input log_write_pkg::dir_entry_s e);
		logic [31:0] res;
		res = 32'h00000000;
		res[log_write_pkg::DIR_SIZE_W-1:0] = e.sectors;
		res[log_write_pkg::DIR_RO_BIT] = e.readOnly;
		res[log_write_pkg::DIR_SUP_BIT] = e.supported;
		return res;
	endfunction

	logic                            commit;
	logic [31:0]                     cur;
	logic [31:0]                     nw;
	logic [log_write_pkg::IRQ_W-1:0] irqClr;
	logic [log_write_pkg::IRQ_W-1:0] irqSet;
	logic                            idle;
	logic                            mapped;

	// The command block is held inside the design; the checker sees only latched values.
	assign cmd.opcode = st_q.opcode;
	assign cmd.count = st_q.count;
	assign cmd.startSector = st_q.startSector;
	assign cmd.logAddr = st_q.logAddr;
	assign cmd.entry = st_q.dir[st_q.logAddr[log_write_pkg::LOG_IDX_W-1:0]];
	assign cmd.load = (st_q.state == log_write_pkg::ST_CHECK) && !cmd.abort;
	assign cmd.take = hostDataValid && hostDataReady;

	assign awready = !st_q.awPend && !st_q.bValid;
	assign wready = !st_q.wPend && !st_q.bValid;
	assign bvalid = st_q.bValid;
	assign bresp = st_q.bResp;
	assign arready = !st_q.rValid;
	assign rvalid = st_q.rValid;
	assign rdata = st_q.rData;
	assign rresp = st_q.rResp;
	assign hostDataReady = (st_q.state == log_write_pkg::ST_XFER);
	assign xferDma = st_q.isDma;
	assign logWrValid = st_q.wrValid;
	assign logWrLog = st_q.wrLog;
	assign logWrSector = st_q.wrSector;
	assign logWrWordIdx = st_q.wrWordIdx;
	assign logWrData = st_q.wrData;
	assign irq = |(st_q.irqSts & st_q.irqEn);

	always_comb
	begin
		st_d = st_q;
		irqClr = '0;
		irqSet = '0;
		cur = 32'h00000000;
		nw = 32'h00000000;
		mapped = 1'b1;
		idle = (st_q.state == log_write_pkg::ST_IDLE);
		commit = st_q.awPend && st_q.wPend && !st_q.bValid;
		st_d.wrValid = 1'b0;

		if (awvalid && awready)
		begin
			st_d.awPend = 1'b1;
			st_d.awAddr = awaddr;
		end
		if (wvalid && wready)
		begin
			st_d.wPend = 1'b1;
			st_d.wData = wdata;
			st_d.wStrb = wstrb;
		end
		if (st_q.bValid && bready)
			st_d.bValid = 1'b0;
		if (st_q.rValid && rready)
			st_d.rValid = 1'b0;

		// Address and data may land in either order; the write acts once both are held.
		if (commit)
		begin
			st_d.awPend = 1'b0;
			st_d.wPend = 1'b0;
			st_d.bValid = 1'b1;
			st_d.bResp = log_write_pkg::RESP_OKAY;
			case (st_q.awAddr)
				log_write_pkg::OFS_SECTOR_COUNT: cur = {16'h0000, st_q.count};
				log_write_pkg::OFS_LOG_ADDRESS: cur = {24'h000000, st_q.logAddr};
				log_write_pkg::OFS_START_SECTOR: cur = {16'h0000, st_q.startSector};
				log_write_pkg::OFS_IRQ_ENABLE: cur = {29'h00000000, st_q.irqEn};
				log_write_pkg::OFS_DIR_SELECT: cur = {27'h0000000, st_q.dirSel};
				log_write_pkg::OFS_DIR_ENTRY: cur = dirWord(st_q.dir[st_q.dirSel]);
				default: cur = 32'h00000000;
			endcase
			nw = mergeBytes(cur, st_q.wData, st_q.wStrb);
			// Parameter writes while a command runs are dropped so the checked values stay stable.
			case (st_q.awAddr)
				log_write_pkg::OFS_SECTOR_COUNT:
					if (idle)
						st_d.count = nw[15:0];
				log_write_pkg::OFS_LOG_ADDRESS:
					if (idle)
						st_d.logAddr = nw[7:0];
				log_write_pkg::OFS_START_SECTOR:
					if (idle)
						st_d.startSector = nw[15:0];
				log_write_pkg::OFS_COMMAND:
					if (idle && st_q.wStrb[0])
					begin
						st_d.opcode = st_q.wData[7:0];
						st_d.state = log_write_pkg::ST_CHECK;
						st_d.status = 8'h00;
						st_d.status[log_write_pkg::STS_BSY] = 1'b1;
						st_d.error = log_write_pkg::ERROR_RESET;
					end
				log_write_pkg::OFS_STATUS, log_write_pkg::OFS_ERROR, log_write_pkg::OFS_IRQ_STATUS: ;
				log_write_pkg::OFS_IRQ_CLEAR: irqClr = st_q.wData[log_write_pkg::IRQ_W-1:0] & {3{st_q.wStrb[0]}};
				log_write_pkg::OFS_IRQ_ENABLE: st_d.irqEn = nw[log_write_pkg::IRQ_W-1:0];
				log_write_pkg::OFS_DIR_SELECT: st_d.dirSel = nw[log_write_pkg::LOG_IDX_W-1:0];
				log_write_pkg::OFS_DIR_ENTRY:
				begin
					st_d.dir[st_q.dirSel].sectors = nw[log_write_pkg::DIR_SIZE_W-1:0];
					st_d.dir[st_q.dirSel].readOnly = nw[log_write_pkg::DIR_RO_BIT];
					st_d.dir[st_q.dirSel].supported = nw[log_write_pkg::DIR_SUP_BIT];
				end
				default: st_d.bResp = log_write_pkg::RESP_SLVERR;
			endcase
		end

		if (arvalid && arready)
		begin
			st_d.rValid = 1'b1;
			case (araddr)
				log_write_pkg::OFS_SECTOR_COUNT: st_d.rData = {16'h0000, st_q.count};
				log_write_pkg::OFS_LOG_ADDRESS: st_d.rData = {24'h000000, st_q.logAddr};
				log_write_pkg::OFS_START_SECTOR: st_d.rData = {16'h0000, st_q.startSector};
				log_write_pkg::OFS_COMMAND: st_d.rData = {24'h000000, st_q.opcode};
				log_write_pkg::OFS_STATUS: st_d.rData = {24'h000000, st_q.status};
				log_write_pkg::OFS_ERROR: st_d.rData = {24'h000000, st_q.error};
				log_write_pkg::OFS_IRQ_STATUS: st_d.rData = {29'h00000000, st_q.irqSts};
				log_write_pkg::OFS_IRQ_CLEAR: st_d.rData = 32'h00000000;
				log_write_pkg::OFS_IRQ_ENABLE: st_d.rData = {29'h00000000, st_q.irqEn};
				log_write_pkg::OFS_DIR_SELECT: st_d.rData = {27'h0000000, st_q.dirSel};
				log_write_pkg::OFS_DIR_ENTRY: st_d.rData = dirWord(st_q.dir[st_q.dirSel]);
				default:
				begin
					st_d.rData = 32'h00000000;
					mapped = 1'b0;
				end
			endcase
			st_d.rResp = mapped ? log_write_pkg::RESP_OKAY : log_write_pkg::RESP_SLVERR;
		end

		case (st_q.state)
			log_write_pkg::ST_IDLE: ;
			log_write_pkg::ST_CHECK:
				if (cmd.abort)
				begin
					st_d.state = log_write_pkg::ST_IDLE;
					st_d.status = 8'h00;
					st_d.status[log_write_pkg::STS_RDY] = 1'b1;
					st_d.status[log_write_pkg::STS_ERR] = 1'b1;
					st_d.error[log_write_pkg::ERR_ABT] = 1'b1;
					irqSet[log_write_pkg::IRQ_ABORT] = 1'b1;
				end
				else
				begin
					st_d.state = log_write_pkg::ST_XFER;
					st_d.isDma = cmd.isDma;
					st_d.status = 8'h00;
					st_d.status[log_write_pkg::STS_RDY] = 1'b1;
					st_d.status[log_write_pkg::STS_DRQ] = 1'b1;
				end
			log_write_pkg::ST_XFER:
				if (cmd.take)
				begin
					st_d.wrValid = 1'b1;
					st_d.wrLog = st_q.logAddr;
					st_d.wrSector = st_q.startSector + cmd.sectorOff;
					st_d.wrWordIdx = cmd.wordIdx;
					st_d.wrData = hostData;
					// In DMA form only completion interrupts; PIO interrupts for every block.
					if (cmd.sectorDone && !st_q.isDma)
						irqSet[log_write_pkg::IRQ_BLOCK] = 1'b1;
					if (cmd.lastWord)
					begin
						st_d.state = log_write_pkg::ST_IDLE;
						st_d.status = 8'h00;
						st_d.status[log_write_pkg::STS_RDY] = 1'b1;
						irqSet[log_write_pkg::IRQ_DONE] = 1'b1;
					end
				end
			default: st_d.state = log_write_pkg::ST_IDLE;
		endcase

		// A new event wins over a clear that lands in the same cycle.
		st_d.irqSts = (st_q.irqSts & ~irqClr) | irqSet;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.status <= log_write_pkg::STATUS_RESET;
			st_q.error <= log_write_pkg::ERROR_RESET;
			// The directory log resets to read-only; a later write to its directory entry can clear that bit.
			st_q.dir[0].readOnly <= 1'b1;
		end
		else
			st_q <= st_d;
	end
endmodule

/* File: test/log_write_command_monitor.sv */
`timescale 1ns/1ps
module log_write_command_monitor (
	input	wire logic		clk_sys,
	input	wire logic		arst_n,
	input	wire logic		awvalid,
	input	wire logic		awready,
	input	wire logic		wvalid,
	input	wire logic		wready,
	input	wire logic [1:0]	bresp,
	input	wire logic		bvalid,
	input	wire logic		bready,
	input	wire logic		arready,
	input	wire logic [31:0]	rdata,
	input	wire logic		rvalid,
	input	wire logic		rready,
	input	wire logic [31:0]	hostData,
	input	wire logic		hostDataValid,
	input	wire logic		hostDataReady,
	input	wire logic		xferDma,
	input	wire logic		logWrValid,
	input	wire logic [31:0]	logWrData
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	ar_gate_a: assert property (rvalid |-> !arready)
		else $error("read address taken while answer pending");
	b_after_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write response late");
	b_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	word_pass_a: assert property (hostDataValid && hostDataReady |=> logWrValid && logWrData == $past(hostData))
		else $error("accepted word not stored next cycle");
	word_cause_a: assert property (logWrValid |-> $past(hostDataValid && hostDataReady))
		else $error("stored word without host transfer");
	mode_steady_a: assert property (hostDataReady && $past(hostDataReady) |-> $stable(xferDma))
		else $error("transfer mode changed mid command");
endmodule
bind log_write_command log_write_command_monitor log_write_command_monitor_i (.clk_sys, .arst_n, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arready, .rdata, .rvalid, .rready, .hostData,
	.hostDataValid, .hostDataReady, .xferDma, .logWrValid, .logWrData);

/* File: test/host_data_source.sv */
`timescale 1ns/1ps
module host_data_source (
	input	wire logic		clk_sys,
	input	wire logic		arst_n,
	input	wire logic		hostDataReady,
	output	logic [31:0]		hostData,
	output	logic			hostDataValid
);
	logic [31:0]	n;
	logic		r;
	// Words are numbered in acceptance order so the bench can predict every stored word.
	// An idle bus shows a changing pattern, since a stale word could hide a capture slip.
	always @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			n <= 32'h0;
			r <= 1'b0;
			hostDataValid <= 1'b0;
			hostData <= 32'h0;
		end
		else
		begin
			r <= ($urandom_range(3, 0) != 0);
			if (!hostDataValid || hostDataReady)
			begin
				hostDataValid <= r;
				hostData <= r ? n + {31'h0, hostDataValid} : ~hostData;
				n <= n + {31'h0, hostDataValid};
			end
		end
	end
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
	logic		clk_sys, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic		arvalid, arready, rvalid, rready, hostDataValid, hostDataReady, xferDma, logWrValid, irq;
	logic [7:0]	awaddr, araddr, logWrLog, eLog;
	logic [31:0]	wdata, rdata, hostData, logWrData, d, nw, kw, eSt;
	logic [3:0]	wstrb;
	logic [1:0]	bresp, rresp, rr;
	logic [15:0]	logWrSector;
	logic [6:0]	logWrWordIdx;
	logic [47:0]	ab [9];
	int		miscompares, cmp_count, i, c, s, n;
	log_write_command log_write_command_i (.clk_sys, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .hostData, .hostDataValid, .hostDataReady, .xferDma, .logWrValid, .logWrLog, .logWrSector,
		.logWrWordIdx, .logWrData, .irq);
	host_data_source host_data_source_i (.clk_sys, .arst_n, .hostDataReady, .hostData, .hostDataValid);
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] sn, input logic [31:0] ex);
		cmp_count++;
		if (sn !== ex)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, sn, ex);
		end
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Sector expected for the k-th stored word of a command that starts at sector st.
	function automatic logic [31:0] expSector(input logic [31:0] st, input logic [31:0] k);
		return st + k / log_write_pkg::WORDS_PER_SECTOR;
	endfunction
	task tmo;
		chk(32'h0, 32'h1);
		results;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; !(ta && tw); k++)
		begin
			@(posedge clk_sys);
			if (!ta && awready === 1'b1) awvalid <= 1'b0;
			if (!tw && wready === 1'b1) wvalid <= 1'b0;
			ta = ta | (awready === 1'b1);
			tw = tw | (wready === 1'b1);
			if (k > 50) tmo;
		end
		for (k = 0; bvalid !== 1'b1; k++)
		begin
			@(posedge clk_sys);
			if (k > 50) tmo;
		end
		chk({30'h0, bresp}, {30'h0, log_write_pkg::RESP_OKAY});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (k > 50) tmo;
		end
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
		begin
			@(posedge clk_sys);
			k++;
			if (k > 100) tmo;
		end
		v = rdata;
		rr = rresp;
	endtask
	task cmd(input logic [7:0] op, input logic [15:0] cn, input logic [7:0] lg, input logic [15:0] st);
		wr(8'h00, {16'h0, cn});
		wr(8'h04, {24'h0, lg});
		wr(8'h08, {16'h0, st});
		eLog = lg;
		eSt = {16'h0, st};
		kw = 32'h0;
		wr(8'h0c, {24'h0, op});
	endtask
	// Every stored word is checked against the host order and the log position it should land in.
	always @(posedge clk_sys)
	begin
		if (arst_n === 1'b1 && logWrValid === 1'b1)
		begin
			chk(logWrData, nw);
			chk({24'h0, logWrLog}, {24'h0, eLog});
			chk({16'h0, logWrSector}, expSector(eSt, kw));
			chk({25'h0, logWrWordIdx}, {25'h0, kw[6:0]});
			nw++;
			kw++;
		end
	end
	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, arvalid, nw, kw, eSt, eLog, rr} = 0;
		{bready, rready, wstrb, miscompares, cmp_count, arst_n} = {1'b1, 1'b1, 4'hf, 64'h0, 1'b0};
		ab = '{48'h3f_0101_05_0000, 48'h3f_0001_06_0000, 48'h57_0001_07_0000, 48'h3f_0000_05_0000,
			48'h3f_0001_05_0003, 48'h3f_0002_05_0002, 48'h57_0001_28_0000, 48'h3f_0001_05_0100,
			48'h20_0001_05_0000};
		void'($urandom(88941));
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(8'h10, d);
		chk(d, 32'h40);
		rd(8'h14, d);
		chk(d, 32'h0);
		rd(8'h2c, d);
		chk({30'h0, rr}, 32'h2);
		wr(8'h24, 32'h0);
		rd(8'h28, d);
		chk(d, 32'h10000);
		for (i = 5; i < 8; i++)
		begin
			wr(8'h24, i);
			wr(8'h28, (i == 7) ? 32'h3 : (i == 6) ? 32'h30003 : 32'h20003);
		end
		wr(8'h20, 32'h7);
		$display("test setup done");
		for (i = 0; i < 2; i++)
		begin
			c = $urandom_range(2, 1);
			s = $urandom_range(3 - c, 0);
			cmd(i ? 8'h57 : 8'h3f, c, 8'h05, s);
			rd(8'h10, d);
			chk(d, 32'h48);
			chk({31'h0, xferDma}, i);
			n = 0;
			do
			begin
				rd(8'h10, d);
				n++;
				if (n > 400) tmo;
			end
			while (d[3] !== 1'b0);
			chk(d, 32'h40);
			chk(kw, c * log_write_pkg::WORDS_PER_SECTOR);
			rd(8'h18, d);
			chk(d, i ? 32'h2 : 32'h3);
			chk({31'h0, irq}, 32'h1);
			wr(8'h1c, 32'h7);
			rd(8'h18, d);
			chk(d, 32'h0);
			chk({31'h0, irq}, 32'h0);
			$display("test transfer %0d done", i);
		end
		// The abort event is masked here so the level output must stay low while its bit is set.
		wr(8'h20, 32'h3);
		for (i = 0; i < 9; i++)
		begin
			cmd(ab[i][47:40], ab[i][39:24], ab[i][23:16], ab[i][15:0]);
			rd(8'h10, d);
			chk(d, 32'h41);
			rd(8'h14, d);
			chk(d, 32'h4);
			rd(8'h18, d);
			chk(d, 32'h4);
			chk({31'h0, irq}, 32'h0);
			chk(kw, 32'h0);
			wr(8'h1c, 32'h7);
		end
		$display("test aborts done");
		results;
	end
endmodule
